// File: verilog/dc_brake_and_motor_set_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// - braking input enables DC injection braking
// - braking delay adjustable 0.1 to 5.0 s
// - braking force adjustable 0 to 100 percent
// - terminal run: brake, then ramp back
// - keypad run: output stays off after release
// - keypad run: coast until delay, then brake
// - function code 07 selects external braking
// - function code 08 selects second bank
// - bank change waits until drive stopped
// - function code 53 swaps bank while running
// - special select swaps only limited subset
// - functions assignable to any of five terminals
module dc_brake_and_motor_set_select #(
   parameter int NUM_TERM   = 5,
   parameter int DELAY_UNIT = brake_set_pkg::TENTH_S_CYCLES
) (
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   input  wire logic [NUM_TERM-1:0]      config_input_terminals,
   input  wire logic [NUM_TERM*8-1:0]    term_func_codes,
   input  wire logic                     forward_run_in,
   input  wire logic                     reverse_run_in,
   input  wire logic                     keypad_run,
   input  wire logic                     motor_stopped,
   input  wire brake_set_pkg::brake_cfg_s brake_cfg,
   output brake_set_pkg::drive_cmd_s     drive_cmd,
   output logic                          bank_full_second,
   output logic                          bank_subset_second,
   output logic                          motor_bank_select_live,
   output logic                          ext_dc_brake_in
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;   // first stage
   logic rst_n;      // synchronised reset

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // terminal conditioning and function decode
   // ----------------------------------------------------------------
   logic [NUM_TERM-1:0] term_clean;   // debounced terminals
   logic [NUM_TERM-1:0] hit_brake;    // terminal mapped to braking and on
   logic [NUM_TERM-1:0] hit_bank;     // terminal mapped to bank select and on
   logic [NUM_TERM-1:0] hit_special;  // terminal mapped to special set and on

   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g++) begin : g_term
         wire [7:0] code = term_func_codes[g*8 +: 8];
         terminal_debounce #(
            .STABLE(brake_set_pkg::DEBOUNCE_CYCLES)
         ) terminal_debounce_inst (
            .mclk  (mclk),
            .rst_n (rst_n),
            .raw   (config_input_terminals[g]),
            .clean (term_clean[g])
         );
         // any terminal may carry any code
         assign hit_brake[g]   = term_clean[g] && code == brake_set_pkg::FUNC_EXT_BRAKE;
         assign hit_bank[g]    = term_clean[g] && code == brake_set_pkg::FUNC_BANK_SELECT;
         assign hit_special[g] = term_clean[g] && code == brake_set_pkg::FUNC_SPECIAL_SET;
      end
   endgenerate

   wire brake_req   = |hit_brake;
   wire bank_req    = |hit_bank;
   wire special_req = |hit_special;
   wire term_run    = forward_run_in | reverse_run_in;

   // ----------------------------------------------------------------
   // setting limits
   // ----------------------------------------------------------------
   // out-of-range settings are clamped rather than rejected, so the
   // brake always has a usable delay and never exceeds full force
   wire [5:0] delay_set = (brake_cfg.brake_delay_time < brake_set_pkg::DELAY_MIN) ?
                          brake_set_pkg::DELAY_MIN :
                          (brake_cfg.brake_delay_time > brake_set_pkg::DELAY_MAX) ?
                          brake_set_pkg::DELAY_MAX : brake_cfg.brake_delay_time;
   wire [6:0] force_set = (brake_cfg.brake_force_level > brake_set_pkg::FORCE_MAX) ?
                          brake_set_pkg::FORCE_MAX : brake_cfg.brake_force_level;

   // ----------------------------------------------------------------
   // braking delay timer: tenth-second tick and tick counter
   // ----------------------------------------------------------------
   logic [31:0] pre_cnt;   // cycles within a tenth
   logic [5:0]  tenths;    // elapsed tenths
   brake_set_pkg::brake_state_e state;
   brake_set_pkg::brake_state_e next_state;

   wire tick       = pre_cnt == 32'(DELAY_UNIT - 1);
   wire delay_done = tenths >= delay_set;

   // timer runs only while coasting
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 32'h0000_0000;
         tenths  <= 6'h00;
      end else if (state != brake_set_pkg::ST_COAST) begin
         pre_cnt <= 32'h0000_0000;
         tenths  <= 6'h00;
      end else if (tick) begin
         pre_cnt <= 32'h0000_0000;
         tenths  <= tenths + 6'h01;
      end else begin
         pre_cnt <= pre_cnt + 32'h0000_0001;
      end
   end

   // coast never passes to braking before the least delay or the programmed count of tenths
   a_delay_min: assert property (@(posedge mclk) disable iff (!rst_n)
      state == brake_set_pkg::ST_COAST && next_state == brake_set_pkg::ST_BRAKE
      |-> tenths >= brake_set_pkg::DELAY_MIN && tenths >= delay_set)
      else $error("brake began before programmed delay");

   // ----------------------------------------------------------------
   // braking sequencer
   // ----------------------------------------------------------------
   // terminal run brakes at once; keypad run coasts through the delay
   always_comb begin
      next_state = state;
      case (state)
         brake_set_pkg::ST_RUN: begin
            if (brake_req) begin
               next_state = keypad_run ? brake_set_pkg::ST_COAST
                                       : brake_set_pkg::ST_BRAKE;
            end
         end
         brake_set_pkg::ST_COAST: begin
            if (!brake_req) begin
               next_state = brake_set_pkg::ST_HOLD_OFF;
            end else if (delay_done) begin
               next_state = brake_set_pkg::ST_BRAKE;
            end
         end
         brake_set_pkg::ST_BRAKE: begin
            if (!brake_req) begin
               next_state = keypad_run ? brake_set_pkg::ST_HOLD_OFF
                                       : brake_set_pkg::ST_RUN;
            end
         end
         brake_set_pkg::ST_HOLD_OFF: begin
            // leave only once both run sources have dropped
            if (!keypad_run && !term_run) begin
               next_state = brake_set_pkg::ST_RUN;
            end
         end
         default: next_state = brake_set_pkg::ST_RUN;
      endcase
   end

   wire braking = next_state == brake_set_pkg::ST_BRAKE;
   wire out_on  = next_state == brake_set_pkg::ST_RUN;
   wire restore = state == brake_set_pkg::ST_BRAKE && next_state == brake_set_pkg::ST_RUN;

   // state and registered drive commands
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= brake_set_pkg::ST_RUN;
         drive_cmd <= '0;
      end else begin
         state                 <= next_state;
         drive_cmd.dc_brake_on <= braking;
         drive_cmd.output_on   <= out_on;
         drive_cmd.ramp_restore <= restore;
         drive_cmd.brake_force <= braking ? force_set : 7'h00;
      end
   end

   // sequencer checks: terminal run brakes at once, keypad run coasts first
   a_term_brake_now: assert property (@(posedge mclk) disable iff (!rst_n)
      state == brake_set_pkg::ST_RUN && brake_req && !keypad_run
      |=> drive_cmd.dc_brake_on)
      else $error("terminal run brake not applied");
   a_keypad_coasts: assert property (@(posedge mclk) disable iff (!rst_n)
      state == brake_set_pkg::ST_RUN && brake_req && keypad_run
      |=> !drive_cmd.dc_brake_on && !drive_cmd.output_on)
      else $error("keypad run did not coast first");
   a_keypad_stays_off: assert property (@(posedge mclk) disable iff (!rst_n)
      state == brake_set_pkg::ST_BRAKE && !brake_req && keypad_run
      |=> !drive_cmd.output_on [*2])
      else $error("output resumed after keypad brake");
   a_ramp_back: assert property (@(posedge mclk) disable iff (!rst_n)
      state == brake_set_pkg::ST_BRAKE && !brake_req && !keypad_run
      |=> drive_cmd.ramp_restore && drive_cmd.output_on)
      else $error("no ramp back after terminal brake");
   // force is bounded and only present while injection braking is on
   a_brake_force_max: assert property (@(posedge mclk) disable iff (!rst_n)
      drive_cmd.brake_force <= brake_set_pkg::FORCE_MAX &&
      (drive_cmd.dc_brake_on || drive_cmd.brake_force == 7'h00))
      else $error("brake force out of range or outside braking");

   // ----------------------------------------------------------------
   // parameter bank selection
   // ----------------------------------------------------------------
   // full bank latches only at standstill; subset follows special or full
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bank_full_second       <= 1'b0;
         bank_subset_second     <= 1'b0;
         motor_bank_select_live <= 1'b0;
         ext_dc_brake_in        <= 1'b0;
      end else begin
         if (motor_stopped) begin
            bank_full_second <= bank_req;
         end
         bank_subset_second     <= special_req |
                                   (motor_stopped ? bank_req : bank_full_second);
         motor_bank_select_live <= special_req;
         ext_dc_brake_in        <= brake_req;
      end
   end

   // full bank moves only at standstill; subset follows special select
   a_bank_holds_running: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(motor_stopped) |-> $stable(bank_full_second))
      else $error("full bank changed while running");
   a_bank_follows_stop: assert property (@(posedge mclk) disable iff (!rst_n)
      motor_stopped |=> bank_full_second == $past(bank_req))
      else $error("full bank did not follow select at standstill");
   a_special_live: assert property (@(posedge mclk) disable iff (!rst_n)
      special_req |=> bank_subset_second)
      else $error("special set did not swap subset");
   // a brake code on any terminal must reach the decoded brake output
   a_decode_code: assert property (@(posedge mclk) disable iff (!rst_n)
      brake_req |=> ext_dc_brake_in)
      else $error("decoded brake terminal not reported");

endmodule

// File: verilog/brake_set_pkg.sv
package brake_set_pkg;

   // ----------------------------------------------------------------
   // terminal function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FUNC_EXT_BRAKE   = 8'h07;
   localparam logic [7:0] FUNC_BANK_SELECT = 8'h08;
   localparam logic [7:0] FUNC_SPECIAL_SET = 8'h35;  // decimal 53

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ          = 200_000_000;
   localparam int TENTH_S_MS      = 100;          // delay setting unit, ms
   localparam int TENTH_S_CYCLES  = CLK_HZ / 1000 * TENTH_S_MS;
   localparam logic [5:0] DELAY_MIN = 6'h01;      // 0.1 s
   localparam logic [5:0] DELAY_MAX = 6'h32;      // 5.0 s
   localparam logic [6:0] FORCE_MAX = 7'h64;      // 100 percent
   localparam int DEBOUNCE_CYCLES = 16;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] brake_delay_time;   // tenths of a second
      logic [6:0] brake_force_level;  // percent
   } brake_cfg_s;

   typedef struct packed {
      logic dc_brake_on;
      logic output_on;
      logic ramp_restore;
      logic [6:0] brake_force;
   } drive_cmd_s;

   typedef enum logic [1:0] {
      ST_RUN      = 2'b00,
      ST_COAST    = 2'b01,
      ST_BRAKE    = 2'b10,
      ST_HOLD_OFF = 2'b11
   } brake_state_e;

endpackage

// File: verilog/terminal_debounce.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// debounce of one terminal: output follows after stable period
// ----------------------------------------------------------------
module terminal_debounce #(
   parameter int STABLE = 16
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic raw,
   output logic      clean
);
   logic       samp;   // registered input
   logic [4:0] cnt;    // stable count
   wire        differ = samp != clean;

   // count while sample disagrees with output, restart on bounce
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         samp  <= 1'b0;
         cnt   <= 5'h00;
         clean <= 1'b0;
      end else begin
         samp <= raw;
         if (!differ || raw != samp) begin
            cnt <= 5'h00;
         end else if (cnt == 5'(STABLE - 1)) begin
            clean <= samp;
            cnt   <= 5'h00;
         end else begin
            cnt <= cnt + 5'h01;
         end
      end
   end
endmodule

// File: verification/terminal_switch_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// switches or controller outputs feeding the input terminals
// ----------------------------------------------------------------
module terminal_switch_model (
   input  wire logic       mclk,
   input  wire logic [4:0] switch_level,
   output logic      [4:0] terminals
);
   // contacts change just after an edge, like a controller output;
   // bounce is produced by the bench toggling switch_level briefly
   initial terminals = 5'h00;
   always @(posedge mclk) begin
      terminals <= switch_level;
   end
endmodule

// File: verification/dc_brake_and_motor_set_select_tb.sv
`timescale 1ns/1ps
module dc_brake_and_motor_set_select_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                              mclk, rstn, fwd, rev, keypad, stopped;
   logic [4:0]                        level;       // requested switch states
   logic [4:0]                        terms;       // terminal pins
   logic [39:0]                       codes;       // function code per terminal
   brake_set_pkg::brake_cfg_s         cfg;
   brake_set_pkg::drive_cmd_s         cmd;
   logic                              bank_full, bank_sub, special_live, brake_live;
   int                                n_errors = 0;
   int                                n_tests = 0;

   terminal_switch_model terminal_switch_model_inst (
      .mclk(mclk), .switch_level(level), .terminals(terms));

   // short delay unit keeps the keypad coast phase to a few cycles
   dc_brake_and_motor_set_select #(.DELAY_UNIT(10)) dc_brake_and_motor_set_select_inst (
      .mclk(mclk), .rstn(rstn), .config_input_terminals(terms), .term_func_codes(codes),
      .forward_run_in(fwd), .reverse_run_in(rev), .keypad_run(keypad),
      .motor_stopped(stopped), .brake_cfg(cfg), .drive_cmd(cmd),
      .bank_full_second(bank_full), .bank_subset_second(bank_sub),
      .motor_bank_select_live(special_live), .ext_dc_brake_in(brake_live));

   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = cmd.dc_brake_on;
         1: pick = cmd.output_on;
         2: pick = cmd.ramp_restore;
         3: pick = bank_full;
         4: pick = bank_sub;
         5: pick = special_live;
         default: pick = brake_live;
      endcase
   endfunction

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // bounded wait, sampled 1 ns after each edge so pulses are seen
   task automatic wait_for(input int sel, input logic val, input int lim, input string what);
      int i;
      for (i = 0; i < lim && pick(sel) !== val; i++) begin
         @(posedge mclk);
         #1;
      end
      chk(what, {9'h000, val}, {9'h000, pick(sel)});
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic run_reset();
      // look once the asynchronous reset has settled, away from the edge
      repeat (4) @(posedge mclk);
      #1;
      chk("cmd in reset", 10'h000, cmd);
      @(posedge mclk) rstn <= 1'b1;
      wait_for(1, 1'b1, 10, "output after reset");
   endtask

   // terminal run: brake on terminal 2, then ramp back on release
   task automatic run_terminal_brake();
      @(posedge mclk) level <= 5'h04;
      wait_for(6, 1'b1, 30, "brake decoded");
      wait_for(0, 1'b1, 5, "dc brake on");
      chk("output during brake", 10'h000, {9'h000, cmd.output_on});
      chk("brake force", 10'h02A, {3'h0, cmd.brake_force});
      @(posedge mclk) level <= 5'h00;
      wait_for(2, 1'b1, 30, "ramp restore");
      chk("brake and output", 10'h001, {8'h00, cmd.dc_brake_on, cmd.output_on});
   endtask

   // a 5-cycle bounce must not reach the decoder
   task automatic run_bounce();
      @(posedge mclk) level <= 5'h04;
      repeat (5) @(posedge mclk);
      level <= 5'h00;
      repeat (30) @(posedge mclk);
      #1;
      chk("bounce filtered", 10'h000, {9'h000, brake_live});
   endtask

   // keypad run: coast for 0.2 s (20 cycles here), brake, stay off
   task automatic run_keypad_brake();
      @(posedge mclk) begin
         codes <= {8'h35, 8'h07, 8'h00, 8'h00, 8'h08};
         fwd <= 1'b0;
         keypad <= 1'b1;
      end
      @(posedge mclk) level <= 5'h08;
      wait_for(6, 1'b1, 30, "brake decoded");
      wait_for(1, 1'b0, 3, "coast output off");
      // two tenths of ten cycles: still coasting at the twentieth edge
      repeat (20) @(posedge mclk);
      #1;
      chk("no brake in delay", 10'h000, {9'h000, cmd.dc_brake_on});
      wait_for(0, 1'b1, 2, "brake after delay");
      @(posedge mclk) level <= 5'h00;
      wait_for(0, 1'b0, 30, "brake released");
      repeat (30) @(posedge mclk);
      #1;
      chk("output held off", 10'h000, {9'h000, cmd.output_on});
      @(posedge mclk) keypad <= 1'b0;
      wait_for(1, 1'b1, 10, "output after stop");
   endtask

   // ordinary select waits for standstill
   task automatic run_bank_select();
      @(posedge mclk) level <= 5'h01;
      repeat (40) @(posedge mclk);
      #1;
      chk("bank held while running", 10'h000, {9'h000, bank_full});
      chk("subset held while running", 10'h000, {9'h000, bank_sub});
      @(posedge mclk) stopped <= 1'b1;
      wait_for(3, 1'b1, 5, "second bank");
      @(posedge mclk) level <= 5'h00;
      wait_for(3, 1'b0, 30, "first bank");
   endtask

   // special select swaps the subset while the motor runs
   task automatic run_special_select();
      @(posedge mclk) begin
         stopped <= 1'b0;
         level <= 5'h10;
      end
      wait_for(5, 1'b1, 30, "special decoded");
      wait_for(4, 1'b1, 3, "subset second");
      chk("full bank kept", 10'h000, {9'h000, bank_full});
      @(posedge mclk) level <= 5'h00;
   endtask

   // reverse terminal run with an over-range force: clamped to full scale
   task automatic run_reverse_clamp();
      @(posedge mclk) begin
         rev <= 1'b1;
         cfg <= '{brake_delay_time: 6'h02, brake_force_level: 7'h7F};
      end
      @(posedge mclk) level <= 5'h08;
      wait_for(0, 1'b1, 30, "reverse run brake");
      chk("clamped force", 10'h064, {3'h0, cmd.brake_force});
      @(posedge mclk) level <= 5'h00;
      wait_for(2, 1'b1, 30, "reverse ramp restore");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      fwd = 1'b1;
      rev = 1'b0;
      keypad = 1'b0;
      stopped = 1'b0;
      level = 5'h00;
      codes = {8'h35, 8'h00, 8'h07, 8'h00, 8'h08};
      cfg = '{brake_delay_time: 6'h02, brake_force_level: 7'h2A};
      run_reset();
      run_terminal_brake();
      run_bounce();
      run_keypad_brake();
      run_bank_select();
      run_special_select();
      run_reverse_clamp();
      final_report();
   end

   // whole run needs well under 1,000 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      final_report();
   end
endmodule
